// *** verilog/trp_pkg.sv ***
/*
  Constants for the touch report policy block: register offsets, reset
  values, field positions, report codes and timing counts.
  Assumes a 100 MHz clock.
*/
package trp_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_FAST_AVG = 8'h04;
  localparam logic [7:0] OFS_SLOW_AVG = 8'h05;
  localparam logic [7:0] OFS_FAST_ACC = 8'h06;
  localparam logic [7:0] OFS_SLOW_ACC = 8'h07;
  localparam logic [7:0] OFS_SPEED_THR = 8'h08;
  localparam logic [7:0] OFS_IDLE_SLEEP = 8'h0A;
  localparam logic [7:0] OFS_RELEASE_DEB = 8'h0B;
  localparam logic [7:0] OFS_ACTION_CFG = 8'h0C;
  localparam logic [7:0] OFS_SEQ_GAP = 8'h0F;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_FAST_AVG = 8'h04;
  localparam logic [7:0] RST_SLOW_AVG = 8'h10;
  localparam logic [7:0] RST_FAST_ACC = 8'h02;
  localparam logic [7:0] RST_SLOW_ACC = 8'h08;
  localparam logic [7:0] RST_SPEED_THR = 8'h04;
  localparam logic [7:0] RST_IDLE_SLEEP = 8'h64;
  localparam logic [7:0] RST_RELEASE_DEB = 8'h80;
  localparam logic [7:0] RST_ACTION_CFG = 8'hB1;
  localparam logic [7:0] RST_SEQ_GAP = 8'hC8;

  // ---------------------------------------------------------------
  // Action field positions and report format
  // ---------------------------------------------------------------
  localparam int INIT_MSB = 7;
  localparam int INIT_LSB = 5;
  localparam int MOVE_MSB = 4;
  localparam int MOVE_LSB = 3;
  localparam int REL_MSB = 2;
  localparam int REL_LSB = 0;
  localparam logic [1:0] MOVE_PEN0 = 2'h1;
  localparam logic [1:0] MOVE_PEN1 = 2'h2;
  localparam logic [7:0] HDR_MARK = 8'h80;
  localparam logic [2:0] REPORT_BYTES = 3'h5;
  localparam int COORD_W = 12;

  // ---------------------------------------------------------------
  // Timing: a shared 10 us tick scales every delay
  // ---------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 10000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int GAP_UNIT_NS = 50000;
  localparam int DEB_UNIT_NS = 240000;
  localparam int SLEEP_UNIT_NS = 100000000;
  localparam int GAP_TICKS = GAP_UNIT_NS / TICK_NS;
  localparam int DEB_TICKS = DEB_UNIT_NS / TICK_NS;
  localparam int SLEEP_TICKS = SLEEP_UNIT_NS / TICK_NS;

  typedef enum logic [1:0] {
    TRP_IDLE,
    TRP_SEND,
    TRP_GAP
  } trp_state_t;

endpackage

// *** verilog/trp_fifo.sv ***
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module trp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic i_clock, // Clock
  input wire logic i_rst_n, // Sync reset, active low
  input wire logic i_in_valid, // Write request
  output logic o_in_ready, // Not full
  input wire logic [W-1:0] i_in_data, // Write data
  output logic o_out_valid, // Not empty
  input wire logic i_out_ready, // Read accept
  output logic [W-1:0] o_out_data // Head word
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] wr_ptr_nxt;
  logic [AW:0] rd_ptr_r;
  logic [AW:0] rd_ptr_nxt;
  logic full;
  logic empty;
  logic do_wr;
  logic do_rd;

  always_comb
  begin
    empty = (wr_ptr_r == rd_ptr_r);
    full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    o_in_ready = !full;
    o_out_valid = !empty;
    o_out_data = mem[rd_ptr_r[AW-1:0]];
    do_wr = i_in_valid && !full;
    do_rd = i_out_ready && !empty;
    wr_ptr_nxt = wr_ptr_r + (AW+1)'(do_wr);
    rd_ptr_nxt = rd_ptr_r + (AW+1)'(do_rd);
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
    end
    if (do_wr)
    begin
      mem[wr_ptr_r[AW-1:0]] <= i_in_data;
    end
  end

  a_no_overrun: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    full && !do_rd |=> wr_ptr_r == $past(wr_ptr_r))
    else $error("fifo pointer moved while full");

endmodule

// *** verilog/trp_top.sv ***
/*
  Touch report policy: sampling and filter choice by speed, sleep timer,
  release debounce and report sequencing into a byte FIFO.
  Assumes measurement samples, touch level and command activity come from
  synchronous logic on the same clock.
*/
// Behaviour
// - Fast motion selects the fast sample averaging count, 1 to 128.
// - Slow motion selects the slow sample averaging count, 1 to 128.
// - Fast motion selects the fast accuracy filter level, 1 to 8.
// - Slow motion selects the slow accuracy filter level, 1 to 8.
// - Motion counts as fast when speed exceeds the 8-bit threshold.
// - Sleep after idle for timeout setting times 100 ms.
// - A timeout setting of zero never sleeps.
// - Touch or command activity wakes the device from sleep.
// - Release starts debounce; touch returning cancels the release report.
// - Debounce lasts the debounce setting times 240 us.
// - Each report carries pen bit: 1 down, 0 up.
// - Initial touch field picks one of six report sequences.
// - Movement field: none, stream with pen 0, or stream with pen 1.
// - Release field uses the same six sequences as initial touch.
// - Reports are five bytes: header with pen bit, then X and Y.
// - Reports in one sequence are spaced by gap setting times 50 us.
`timescale 1ns/1ns
module trp_top #(
  parameter int P_TICK_CYCLES = trp_pkg::TICK_CYCLES,
  parameter int P_FIFO_DEPTH = 8
) (
  input wire logic i_clock, // 100 MHz clock
  input wire logic i_rst_n, // Sync reset, active low
  input wire logic i_reg_we, // Register write strobe
  input wire logic [7:0] i_reg_addr, // Register offset
  input wire logic [7:0] i_reg_wdata, // Register write data
  output logic [7:0] o_reg_rdata, // Register read data
  input wire logic i_touch_down, // Touch present level
  input wire logic i_sample_valid, // Averaged sample pulse
  input wire logic [11:0] i_x, // X coordinate
  input wire logic [11:0] i_y, // Y coordinate
  input wire logic [7:0] i_speed, // Movement speed
  input wire logic i_cmd_activity, // Command byte pulse
  output logic o_fast_motion, // Fast motion class
  output logic [7:0] o_sample_avg, // Active averaging count
  output logic [7:0] o_accuracy_level, // Active filter level
  output logic o_sleep, // Low power sleep
  output logic o_pen_active, // Pen held down
  output logic o_tx_valid, // Report byte valid
  input wire logic i_tx_ready, // Report byte accept
  output logic [7:0] o_tx_data // Report byte
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] fast_avg_r, slow_avg_r, fast_acc_r, slow_acc_r, thr_r;
  logic [7:0] sleep_r, deb_r, cfg_r, gap_r, rdata_nxt;

  always_comb
  begin
    unique case (i_reg_addr)
      trp_pkg::OFS_FAST_AVG: rdata_nxt = fast_avg_r;
      trp_pkg::OFS_SLOW_AVG: rdata_nxt = slow_avg_r;
      trp_pkg::OFS_FAST_ACC: rdata_nxt = fast_acc_r;
      trp_pkg::OFS_SLOW_ACC: rdata_nxt = slow_acc_r;
      trp_pkg::OFS_SPEED_THR: rdata_nxt = thr_r;
      trp_pkg::OFS_IDLE_SLEEP: rdata_nxt = sleep_r;
      trp_pkg::OFS_RELEASE_DEB: rdata_nxt = deb_r;
      trp_pkg::OFS_ACTION_CFG: rdata_nxt = cfg_r;
      trp_pkg::OFS_SEQ_GAP: rdata_nxt = gap_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      fast_avg_r <= trp_pkg::RST_FAST_AVG;
      slow_avg_r <= trp_pkg::RST_SLOW_AVG;
      fast_acc_r <= trp_pkg::RST_FAST_ACC;
      slow_acc_r <= trp_pkg::RST_SLOW_ACC;
      thr_r <= trp_pkg::RST_SPEED_THR;
      sleep_r <= trp_pkg::RST_IDLE_SLEEP;
      deb_r <= trp_pkg::RST_RELEASE_DEB;
      cfg_r <= trp_pkg::RST_ACTION_CFG;
      gap_r <= trp_pkg::RST_SEQ_GAP;
      o_reg_rdata <= 8'h00;
    end
    else
    begin
      o_reg_rdata <= rdata_nxt;
      if (i_reg_we && i_reg_addr == trp_pkg::OFS_FAST_AVG) fast_avg_r <= i_reg_wdata;
      if (i_reg_we && i_reg_addr == trp_pkg::OFS_SLOW_AVG) slow_avg_r <= i_reg_wdata;
      if (i_reg_we && i_reg_addr == trp_pkg::OFS_FAST_ACC) fast_acc_r <= i_reg_wdata;
      if (i_reg_we && i_reg_addr == trp_pkg::OFS_SLOW_ACC) slow_acc_r <= i_reg_wdata;
      if (i_reg_we && i_reg_addr == trp_pkg::OFS_SPEED_THR) thr_r <= i_reg_wdata;
      if (i_reg_we && i_reg_addr == trp_pkg::OFS_IDLE_SLEEP) sleep_r <= i_reg_wdata;
      if (i_reg_we && i_reg_addr == trp_pkg::OFS_RELEASE_DEB) deb_r <= i_reg_wdata;
      if (i_reg_we && i_reg_addr == trp_pkg::OFS_ACTION_CFG) cfg_r <= i_reg_wdata;
      if (i_reg_we && i_reg_addr == trp_pkg::OFS_SEQ_GAP) gap_r <= i_reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Speed class, averaging and filter choice
  // ---------------------------------------------------------------
  logic fast_nxt;
  logic [7:0] avg_nxt, acc_nxt;

  always_comb
  begin
    fast_nxt = o_fast_motion;
    if (i_sample_valid)
    begin
      fast_nxt = (i_speed > thr_r);
    end
    avg_nxt = fast_nxt ? fast_avg_r : slow_avg_r;
    acc_nxt = fast_nxt ? fast_acc_r : slow_acc_r;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_fast_motion <= 1'b0;
      o_sample_avg <= trp_pkg::RST_SLOW_AVG;
      o_accuracy_level <= trp_pkg::RST_SLOW_ACC;
    end
    else
    begin
      o_fast_motion <= fast_nxt;
      o_sample_avg <= avg_nxt;
      o_accuracy_level <= acc_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Tick, sleep and debounce timers
  // ---------------------------------------------------------------
  logic [15:0] pre_r, pre_nxt;
  logic tick;
  logic [31:0] idle_r, idle_nxt, deb_cnt_r, deb_cnt_nxt;
  logic [31:0] sleep_target, deb_target;
  logic sleep_nxt, pen_nxt, release_go;
  logic activity;
  trp_pkg::trp_state_t st_r, st_nxt;

  always_comb
  begin
    tick = (pre_r == 16'(P_TICK_CYCLES - 1));
    pre_nxt = tick ? 16'h0000 : pre_r + 16'h0001;
    activity = i_touch_down || i_cmd_activity;
    sleep_target = 32'(sleep_r) * 32'(trp_pkg::SLEEP_TICKS);
    deb_target = 32'(deb_r) * 32'(trp_pkg::DEB_TICKS);
    idle_nxt = idle_r;
    if (activity)
    begin
      idle_nxt = 32'h0000_0000;
    end
    else if (tick && idle_r < sleep_target)
    begin
      idle_nxt = idle_r + 32'h0000_0001;
    end
    sleep_nxt = o_sleep;
    if (activity)
    begin
      sleep_nxt = 1'b0;
    end
    else if (sleep_r != 8'h00 && idle_r >= sleep_target)
    begin
      sleep_nxt = 1'b1;
    end
    deb_cnt_nxt = deb_cnt_r;
    if (i_touch_down || !o_pen_active)
    begin
      deb_cnt_nxt = 32'h0000_0000;
    end
    else if (tick && deb_cnt_r < deb_target)
    begin
      deb_cnt_nxt = deb_cnt_r + 32'h0000_0001;
    end
    release_go = o_pen_active && !i_touch_down && deb_cnt_r >= deb_target
      && st_r == trp_pkg::TRP_IDLE;
    pen_nxt = o_pen_active;
    if (release_go)
    begin
      pen_nxt = 1'b0;
    end
    else if (!o_pen_active && i_touch_down && i_sample_valid && st_r == trp_pkg::TRP_IDLE)
    begin
      pen_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      pre_r <= 16'h0000;
      idle_r <= 32'h0000_0000;
      deb_cnt_r <= 32'h0000_0000;
      o_sleep <= 1'b0;
      o_pen_active <= 1'b0;
    end
    else
    begin
      pre_r <= pre_nxt;
      idle_r <= idle_nxt;
      deb_cnt_r <= deb_cnt_nxt;
      o_sleep <= sleep_nxt;
      o_pen_active <= pen_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Report sequencer
  // ---------------------------------------------------------------
  logic [2:0] bits_r, bits_nxt, code_bits;
  logic [1:0] left_r, left_nxt, code_len;
  logic [2:0] idx_r, idx_nxt;
  logic [11:0] x_r, x_nxt, y_r, y_nxt;
  logic [31:0] gap_cnt_r, gap_cnt_nxt, gap_target;
  logic [2:0] code;
  logic start, move_go;
  logic push, push_ready, fifo_valid;
  logic [7:0] push_data, fifo_data;

  always_comb
  begin
    start = 1'b0;
    code = 3'h0;
    move_go = 1'b0;
    if (release_go)
    begin
      start = 1'b1;
      code = cfg_r[trp_pkg::REL_MSB:trp_pkg::REL_LSB];
    end
    else if (pen_nxt && !o_pen_active)
    begin
      start = 1'b1;
      code = cfg_r[trp_pkg::INIT_MSB:trp_pkg::INIT_LSB];
    end
    else if (o_pen_active && i_touch_down && i_sample_valid && st_r == trp_pkg::TRP_IDLE)
    begin
      move_go = 1'b1;
    end
    // Pen bits sent first in bit 0
    unique case (code)
      3'h1: begin code_len = 2'h1; code_bits = 3'h0; end
      3'h2: begin code_len = 2'h1; code_bits = 3'h1; end
      3'h3: begin code_len = 2'h2; code_bits = 3'h1; end
      3'h4: begin code_len = 2'h3; code_bits = 3'h2; end
      3'h5: begin code_len = 2'h2; code_bits = 3'h2; end
      default: begin code_len = 2'h0; code_bits = 3'h0; end
    endcase
    if (move_go)
    begin
      unique case (cfg_r[trp_pkg::MOVE_MSB:trp_pkg::MOVE_LSB])
        trp_pkg::MOVE_PEN0: begin code_len = 2'h1; code_bits = 3'h0; end
        trp_pkg::MOVE_PEN1: begin code_len = 2'h1; code_bits = 3'h1; end
        default: begin code_len = 2'h0; code_bits = 3'h0; end
      endcase
    end
    gap_target = 32'(gap_r) * 32'(trp_pkg::GAP_TICKS);
    st_nxt = st_r;
    bits_nxt = bits_r;
    left_nxt = left_r;
    idx_nxt = idx_r;
    x_nxt = x_r;
    y_nxt = y_r;
    gap_cnt_nxt = gap_cnt_r;
    unique case (idx_r)
      3'h0: push_data = trp_pkg::HDR_MARK | {7'h00, bits_r[0]};
      3'h1: push_data = {1'b0, x_r[6:0]};
      3'h2: push_data = {3'h0, x_r[11:7]};
      3'h3: push_data = {1'b0, y_r[6:0]};
      default: push_data = {3'h0, y_r[11:7]};
    endcase
    push = (st_r == trp_pkg::TRP_SEND);
    unique case (st_r)
      trp_pkg::TRP_IDLE:
      begin
        if ((start || move_go) && code_len != 2'h0)
        begin
          st_nxt = trp_pkg::TRP_SEND;
          bits_nxt = code_bits;
          left_nxt = code_len;
          idx_nxt = 3'h0;
          if (i_sample_valid)
          begin
            x_nxt = i_x;
            y_nxt = i_y;
          end
        end
        else if (i_sample_valid && i_touch_down)
        begin
          x_nxt = i_x;
          y_nxt = i_y;
        end
      end
      trp_pkg::TRP_SEND:
      begin
        if (push_ready)
        begin
          idx_nxt = idx_r + 3'h1;
          if (idx_r == trp_pkg::REPORT_BYTES - 3'h1)
          begin
            idx_nxt = 3'h0;
            left_nxt = left_r - 2'h1;
            bits_nxt = {1'b0, bits_r[2:1]};
            gap_cnt_nxt = 32'h0000_0000;
            st_nxt = (left_r == 2'h1) ? trp_pkg::TRP_IDLE : trp_pkg::TRP_GAP;
          end
        end
      end
      trp_pkg::TRP_GAP:
      begin
        if (gap_cnt_r >= gap_target)
        begin
          st_nxt = trp_pkg::TRP_SEND;
        end
        else if (tick)
        begin
          gap_cnt_nxt = gap_cnt_r + 32'h0000_0001;
        end
      end
      default: st_nxt = trp_pkg::TRP_IDLE;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      st_r <= trp_pkg::TRP_IDLE;
      bits_r <= 3'h0;
      left_r <= 2'h0;
      idx_r <= 3'h0;
      x_r <= 12'h000;
      y_r <= 12'h000;
      gap_cnt_r <= 32'h0000_0000;
    end
    else
    begin
      st_r <= st_nxt;
      bits_r <= bits_nxt;
      left_r <= left_nxt;
      idx_r <= idx_nxt;
      x_r <= x_nxt;
      y_r <= y_nxt;
      gap_cnt_r <= gap_cnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Report FIFO and output stage
  // ---------------------------------------------------------------
  logic pop;
  logic tx_valid_nxt;
  logic [7:0] tx_data_nxt;

  trp_fifo #(.W(8), .D(P_FIFO_DEPTH)) u_fifo (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_in_valid(push),
    .o_in_ready(push_ready),
    .i_in_data(push_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(pop),
    .o_out_data(fifo_data)
  );

  always_comb
  begin
    pop = !o_tx_valid || i_tx_ready;
    tx_valid_nxt = pop ? fifo_valid : o_tx_valid;
    tx_data_nxt = (pop && fifo_valid) ? fifo_data : o_tx_data;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_tx_valid <= 1'b0;
      o_tx_data <= 8'h00;
    end
    else
    begin
      o_tx_valid <= tx_valid_nxt;
      o_tx_data <= tx_data_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_held_release;
    o_pen_active && !i_touch_down && deb_cnt_r < deb_target;
  endsequence
  sequence s_last_byte;
    push && push_ready && idx_r == trp_pkg::REPORT_BYTES - 3'h1 && left_r > 2'h1;
  endsequence

  a_speed_class: assert property (i_sample_valid |=> o_fast_motion ==
    ($past(i_speed) > $past(thr_r))) else $error("speed class wrong");
  a_fast_avg: assert property (i_sample_valid && i_speed > thr_r && !i_reg_we
    |=> o_sample_avg == fast_avg_r) else $error("fast averaging not chosen");
  a_slow_avg: assert property (i_sample_valid && i_speed <= thr_r && !i_reg_we
    |=> o_sample_avg == slow_avg_r) else $error("slow averaging not chosen");
  a_fast_filter: assert property (o_fast_motion && $stable(fast_acc_r)
    |=> o_accuracy_level == $past(fast_acc_r) || !o_fast_motion) else $error("fast filter wrong");
  a_slow_filter: assert property (!o_fast_motion && $stable(slow_acc_r)
    |=> o_accuracy_level == $past(slow_acc_r) || o_fast_motion) else $error("slow filter wrong");
  a_sleep_entry: assert property (!activity && sleep_r != 8'h00 && idle_r >= sleep_target
    |=> o_sleep) else $error("sleep not entered");
  a_sleep_never: assert property (sleep_r == 8'h00 && !o_sleep |=> !o_sleep)
    else $error("slept with zero timeout");
  a_wake_up: assert property (activity |=> !o_sleep ##0 idle_r == 32'h0000_0000)
    else $error("no wake on activity");
  a_debounce_hold: assert property (s_held_release |=> o_pen_active)
    else $error("release before debounce expired");
  a_header_byte: assert property (push && idx_r == 3'h0 |-> push_data[7]
    && push_data[0] == bits_r[0]) else $error("bad report header");
  a_undef_code: assert property (st_r == trp_pkg::TRP_IDLE && start && code > 3'h5
    |=> st_r == trp_pkg::TRP_IDLE) else $error("report from undefined code");
  a_gap_wait: assert property (s_last_byte |=> st_r == trp_pkg::TRP_GAP
    ##0 (gap_target == 32'h0000_0000 || st_r == trp_pkg::TRP_GAP)[*2])
    else $error("sequence gap skipped");

endmodule

// *** verif/trp_host_sink.sv ***
/*
  Host side model: accepts report bytes with a fixed stall pattern.
  Assumes the bench samples o_got and o_byte after each rising edge.
*/
`timescale 1ns/1ns
module trp_host_sink (
  input wire logic i_clock, // Clock
  input wire logic i_hold, // Bench stall request
  input wire logic i_valid, // Byte offered
  input wire logic [7:0] i_data, // Offered byte
  output logic o_ready, // Byte accept
  output logic o_got, // Byte taken at last edge
  output logic [7:0] o_byte // Taken byte
);
  logic [1:0] cnt_r = 2'h0;
  initial o_ready = 1'b0;
  initial o_got = 1'b0;
  initial o_byte = 8'h00;
  // Ready three cycles in four, never while held
  always @(posedge i_clock)
  begin
    o_got <= i_valid & o_ready;
    o_byte <= i_data;
    cnt_r <= cnt_r + 2'h1;
    o_ready <= !i_hold && (cnt_r != 2'h2);
  end
endmodule

// *** verif/tb_touch_report_policy.sv ***
/*
  Bench for trp_top: queue model of report sequences, registers,
  speed class, debounce and sleep.
  Assumes the tick parameter is shrunk to 2 cycles.
*/
`timescale 1ns/1ns
module tb_touch_report_policy;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_reg_we = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_touch_down = 1'b0;
  logic i_sample_valid = 1'b0;
  logic [11:0] i_x = 12'h000;
  logic [11:0] i_y = 12'h000;
  logic [7:0] i_speed = 8'h00;
  logic i_cmd_activity = 1'b0;
  logic hold = 1'b0;
  logic i_tx_ready, o_fast_motion, o_sleep, o_pen_active, o_tx_valid, got;
  logic [7:0] o_reg_rdata, o_sample_avg, o_accuracy_level, o_tx_data, got_byte;
  integer fail_count = 0;
  integer n_tests = 0;
  integer seed = 32'h117b30f4;
  integer cyc = 0;
  logic [7:0] rx[$];
  logic [7:0] ex[$];
  int seq_n[8] = '{0, 1, 1, 2, 3, 2, 0, 0};
  int seq_p[8] = '{0, 0, 1, 1, 2, 2, 0, 0};

  always #5 i_clock = ~i_clock;

  trp_top #(.P_TICK_CYCLES(2), .P_FIFO_DEPTH(8)) uut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_reg_we(i_reg_we), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_touch_down(i_touch_down), .i_sample_valid(i_sample_valid),
    .i_x(i_x), .i_y(i_y), .i_speed(i_speed), .i_cmd_activity(i_cmd_activity),
    .o_fast_motion(o_fast_motion), .o_sample_avg(o_sample_avg),
    .o_accuracy_level(o_accuracy_level), .o_sleep(o_sleep), .o_pen_active(o_pen_active),
    .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready), .o_tx_data(o_tx_data));

  trp_host_sink host (.i_clock(i_clock), .i_hold(hold), .i_valid(o_tx_valid),
    .i_data(o_tx_data), .o_ready(i_tx_ready), .o_got(got), .o_byte(got_byte));

  // ---------------------------------------------------------------
  // Capture and watchdog
  // ---------------------------------------------------------------
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (got === 1'b1)
      rx.push_back(got_byte);
    if (cyc == 100000)
    begin
      fail_count = fail_count + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("tests %0d failures %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      fail_count = fail_count + 1;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_we = 1'b1;
    tick(1);
    i_reg_we = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_reg_addr = a;
    tick(2);
    chk(o_reg_rdata, e, "reg");
  endtask

  task automatic sample(input logic [7:0] s);
    i_speed = s;
    i_sample_valid = 1'b1;
    tick(1);
    i_sample_valid = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Report model
  // ---------------------------------------------------------------
  task automatic add(input logic p);
    ex.push_back({7'h40, p});
    ex.push_back({1'b0, i_x[6:0]});
    ex.push_back({3'h0, i_x[11:7]});
    ex.push_back({1'b0, i_y[6:0]});
    ex.push_back({3'h0, i_y[11:7]});
  endtask

  task automatic add_seq(input int c);
    for (int k = 0; k < seq_n[c]; k++)
      add(seq_p[c][k]);
  endtask

  task automatic drain(input string m);
    int t;
    t = 0;
    while (rx.size() < ex.size() && t < 3000)
    begin
      tick(1);
      t++;
    end
    tick(100);
    chk(8'(rx.size()), 8'(ex.size()), m);
    while (ex.size() > 0 && rx.size() > 0)
      chk(rx.pop_front(), ex.pop_front(), m);
    rx.delete();
    ex.delete();
    $display("test %s done", m);
  endtask

  initial
  begin
    tick(20);
    i_rst_n = 1'b1;
    rd(trp_pkg::OFS_FAST_AVG, trp_pkg::RST_FAST_AVG);
    rd(trp_pkg::OFS_SLOW_AVG, trp_pkg::RST_SLOW_AVG);
    rd(trp_pkg::OFS_FAST_ACC, trp_pkg::RST_FAST_ACC);
    rd(trp_pkg::OFS_SLOW_ACC, trp_pkg::RST_SLOW_ACC);
    rd(trp_pkg::OFS_SPEED_THR, trp_pkg::RST_SPEED_THR);
    rd(trp_pkg::OFS_IDLE_SLEEP, trp_pkg::RST_IDLE_SLEEP);
    rd(trp_pkg::OFS_RELEASE_DEB, trp_pkg::RST_RELEASE_DEB);
    rd(trp_pkg::OFS_ACTION_CFG, trp_pkg::RST_ACTION_CFG);
    rd(trp_pkg::OFS_SEQ_GAP, trp_pkg::RST_SEQ_GAP);
    wr(8'h01, 8'h5A);
    rd(8'h01, 8'h00);
    wr(trp_pkg::OFS_SPEED_THR, 8'h40);
    sample(8'h40);
    tick(1);
    chk(o_fast_motion, 1'b0, "slow");
    chk(o_sample_avg, trp_pkg::RST_SLOW_AVG, "slow avg");
    chk(o_accuracy_level, trp_pkg::RST_SLOW_ACC, "slow acc");
    sample(8'h41);
    tick(1);
    chk(o_fast_motion, 1'b1, "fast");
    chk(o_sample_avg, trp_pkg::RST_FAST_AVG, "fast avg");
    chk(o_accuracy_level, trp_pkg::RST_FAST_ACC, "fast acc");
    wr(trp_pkg::OFS_FAST_AVG, 8'h80);
    wr(trp_pkg::OFS_FAST_ACC, 8'h08);
    chk(o_sample_avg, 8'h80, "avg wr");
    chk(o_accuracy_level, 8'h08, "acc wr");
    $display("test config done");
    wr(trp_pkg::OFS_IDLE_SLEEP, 8'h00);
    wr(trp_pkg::OFS_RELEASE_DEB, 8'h01);
    wr(trp_pkg::OFS_SEQ_GAP, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      wr(trp_pkg::OFS_ACTION_CFG, {i[2:0], i[1:0], 3'(7 - i)});
      i_x = 12'($random(seed));
      i_y = 12'($random(seed));
      i_touch_down = 1'b1;
      hold = (i == 4);
      sample(8'h00);
      add_seq(i);
      tick(200);
      chk(o_tx_valid, hold, "stall");
      hold = 1'b0;
      drain("down");
      sample(8'($random(seed)));
      if (i[1] != i[0])
        add(i[1]);
      drain("move");
      i_touch_down = 1'b0;
      add_seq(7 - i);
      drain("up");
      chk(o_pen_active, 1'b0, "pen");
    end
    chk(o_sleep, 1'b0, "no sleep");
    wr(trp_pkg::OFS_ACTION_CFG, 8'h51);
    i_touch_down = 1'b1;
    sample(8'h00);
    add(1'b1);
    drain("bounce down");
    i_touch_down = 1'b0;
    tick(30);
    chk(o_pen_active, 1'b1, "debounce");
    i_touch_down = 1'b1;
    drain("cancel");
    i_touch_down = 1'b0;
    tick(40);
    chk(o_pen_active, 1'b1, "deb len");
    tick(14);
    chk(o_pen_active, 1'b0, "deb end");
    add(1'b0);
    drain("release");
    wr(trp_pkg::OFS_IDLE_SLEEP, 8'h01);
    i_cmd_activity = 1'b1;
    tick(1);
    i_cmd_activity = 1'b0;
    tick(19900);
    chk(o_sleep, 1'b0, "awake");
    tick(200);
    chk(o_sleep, 1'b1, "asleep");
    i_cmd_activity = 1'b1;
    tick(1);
    i_cmd_activity = 1'b0;
    tick(1);
    chk(o_sleep, 1'b0, "cmd wake");
    tick(19900);
    chk(o_sleep, 1'b0, "restart");
    tick(300);
    chk(o_sleep, 1'b1, "asleep again");
    i_touch_down = 1'b1;
    tick(2);
    chk(o_sleep, 1'b0, "touch wake");
    $display("test sleep done");
    summarize();
  end
endmodule
